// ==== rtl/apsp_pkg.sv ====
package apsp_pkg;

	// Address and request-type line ranges on the bus
	localparam int ADDR_HI      = 35;
	localparam int ADDR_LO      = 3;
	localparam int REQ_W        = 5;
	localparam int LOW_GRP_TOP  = 16;
	localparam int HIGH_GRP_BOT = 17;
	localparam int PAR_SPLIT    = 24;

	// Strobe and parity bit positions
	localparam int STB_LOW      = 0;
	localparam int STB_HIGH     = 1;
	localparam int PAR_ZERO     = 0;
	localparam int PAR_ONE      = 1;

	// Bus clock divider: half period in clk cycles
	localparam int DIV_W        = 4;
	localparam logic [DIV_W-1:0] BCLK_HALF_CYC = 4'h2;

	typedef logic [ADDR_HI:ADDR_LO] apsp_addr_t;
	typedef logic [REQ_W-1:0]       apsp_req_t;

	// Pin-level parity: a bit is high when an even number of covered lines are low
	function automatic logic [1:0] apsp_parity(input apsp_addr_t a_n,
		input apsp_req_t r_n, input logic sp2);
		logic hi;
		logic lo;
		hi = ~^(~a_n[ADDR_HI:PAR_SPLIT]);
		lo = ~^{~a_n[PAR_SPLIT-1:ADDR_LO], ~r_n};
		return sp2 ? {hi, lo} : {lo, hi};
	endfunction

endpackage

// ==== rtl/apsp_bus_if.sv ====
`timescale 1ns/1ps
interface apsp_bus_if;
	import apsp_pkg::*;

	// Bus clock, made by the requesting end
	logic       bclk;

	// Drivers of the requesting end
	apsp_addr_t addr_o;
	logic       addr_oe;
	apsp_req_t  req_type_o;
	logic       req_type_oe;
	logic [1:0] address_parity_bits_o;
	logic       address_parity_bits_oe;
	logic       address_valid_strobe_o;
	logic       address_valid_strobe_oe;
	logic [1:0] address_source_strobes_o;
	logic       address_source_strobes_oe;

	// Resolved wire levels; undriven lines float high through termination
	apsp_addr_t addr_n;
	apsp_req_t  req_type_n;
	logic [1:0] address_parity_bits_n;
	logic       address_valid_strobe_n;
	logic [1:0] address_source_strobes_n;

	assign addr_n                   = addr_oe ? addr_o : '1;
	assign req_type_n               = req_type_oe ? req_type_o : '1;
	assign address_parity_bits_n    = address_parity_bits_oe ? address_parity_bits_o : '1;
	assign address_valid_strobe_n   = address_valid_strobe_oe ? address_valid_strobe_o : 1'b1;
	assign address_source_strobes_n = address_source_strobes_oe ? address_source_strobes_o : '1;

	modport requester (
		output bclk,
		output addr_o,
		output addr_oe,
		output req_type_o,
		output req_type_oe,
		output address_parity_bits_o,
		output address_parity_bits_oe,
		output address_valid_strobe_o,
		output address_valid_strobe_oe,
		output address_source_strobes_o,
		output address_source_strobes_oe
	);

	modport agent (
		input bclk,
		input addr_n,
		input req_type_n,
		input address_parity_bits_n,
		input address_valid_strobe_n,
		input address_source_strobes_n
	);

endinterface

// ==== rtl/apsp_requester.sv ====
`timescale 1ns/1ps
module apsp_requester
	import apsp_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Bus
	apsp_bus_if.requester   bus,
	// Request port
	input  wire logic       req_valid,
	output logic            req_ready,
	input  wire apsp_addr_t req_addr,
	input  wire apsp_addr_t req_info,
	input  wire apsp_req_t  req_type_a,
	input  wire apsp_req_t  req_type_b,
	input  wire logic [1:0] req_bad_parity,
	output logic            phase_done
);

	typedef enum logic [1:0] {APSP_IDLE, APSP_LOAD, APSP_SP1, APSP_SP2} apsp_hst_t;

	apsp_hst_t        state_r;
	apsp_hst_t        state_nxt;
	logic [DIV_W-1:0] div_r;
	logic             bclk_r;
	logic             div_run_r;
	apsp_addr_t       addr_h_r;
	apsp_addr_t       info_h_r;
	apsp_req_t        ta_h_r;
	apsp_req_t        tb_h_r;
	logic [1:0]       bad_h_r;
	apsp_addr_t       addr_o_r;
	apsp_req_t        req_o_r;
	logic [1:0]       par_o_r;
	logic             avs_o_r;
	logic [1:0]       stb_o_r;
	logic             oe_r;
	logic             avs_oe_r;
	logic             ready_r;
	logic             done_r;

	wire        div_wrap = (div_r == BCLK_HALF_CYC - 4'h1);
	wire        fall     = div_wrap & bclk_r;
	wire        take     = req_valid & ready_r;
	wire [1:0]  par_sp1  = apsp_parity(~addr_h_r, ~ta_h_r, 1'b0) ^ bad_h_r;
	wire [1:0]  par_sp2  = apsp_parity(~info_h_r, ~tb_h_r, 1'b1) ^ bad_h_r;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			APSP_IDLE: state_nxt = take ? APSP_LOAD : APSP_IDLE;
			APSP_LOAD: state_nxt = fall ? APSP_SP1 : APSP_LOAD;
			APSP_SP1:  state_nxt = fall ? APSP_SP2 : APSP_SP1;
			APSP_SP2:  state_nxt = fall ? APSP_IDLE : APSP_SP2;
			default:   state_nxt = APSP_IDLE;
		endcase
	end

	// Bus clock divider; every launch happens on its falling edge
	// Starts at the first reset, then runs through later ones so the far end sees reset
	always_ff @(posedge clk)
	begin
		div_run_r <= div_run_r | ~rst_n;
		if (div_run_r)
		begin
			div_r  <= div_wrap ? '0 : div_r + 4'h1;
			bclk_r <= div_wrap ? ~bclk_r : bclk_r; // R7
		end
		else
		begin
			div_r  <= '0;
			bclk_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_r <= APSP_IDLE;
			ready_r <= 1'b1;
			done_r  <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			ready_r <= (state_nxt == APSP_IDLE);
			done_r  <= (state_r == APSP_SP2) & fall;
		end
	end

	always_ff @(posedge clk)
	begin
		if (take)
		begin
			addr_h_r <= req_addr;
			info_h_r <= req_info;
			ta_h_r   <= req_type_a;
			tb_h_r   <= req_type_b;
			bad_h_r  <= req_bad_parity;
		end
	end

	// Pins are active low: user values are inverted on launch
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			addr_o_r <= '1;
			req_o_r  <= '1;
			par_o_r  <= '1;
			avs_o_r  <= 1'b1;
			stb_o_r  <= '1;
			oe_r     <= 1'b0;
			avs_oe_r <= 1'b0;
		end
		else if (fall)
		begin
			case (state_r)
				APSP_LOAD:
				begin
					addr_o_r <= ~addr_h_r; // R8
					req_o_r  <= ~ta_h_r;
					par_o_r  <= par_sp1; // R3 R4 R5 R6
					avs_o_r  <= 1'b0; // R9
					stb_o_r  <= 2'h0; // R1 R2
					oe_r     <= 1'b1;
					avs_oe_r <= 1'b1;
				end
				APSP_SP1:
				begin
					addr_o_r <= ~info_h_r; // R8
					req_o_r  <= ~tb_h_r;
					par_o_r  <= par_sp2; // R3 R4 R5 R6
					avs_o_r  <= 1'b1;
					stb_o_r  <= 2'h3; // R1 R2
				end
				APSP_SP2:
				begin
					oe_r     <= 1'b0;
					avs_oe_r <= 1'b0;
				end
				default:
				begin
					oe_r     <= oe_r;
				end
			endcase
		end
	end

	assign bus.bclk                      = bclk_r;
	assign bus.addr_o                    = addr_o_r;
	assign bus.addr_oe                   = oe_r;
	assign bus.req_type_o                = req_o_r;
	assign bus.req_type_oe               = oe_r;
	assign bus.address_parity_bits_o     = par_o_r;
	assign bus.address_parity_bits_oe    = oe_r;
	assign bus.address_valid_strobe_o    = avs_o_r;
	assign bus.address_valid_strobe_oe   = avs_oe_r;
	assign bus.address_source_strobes_o  = stb_o_r;
	assign bus.address_source_strobes_oe = oe_r;
	assign req_ready                     = ready_r;
	assign phase_done                    = done_r;

endmodule

// ==== rtl/apsp_agent.sv ====
`timescale 1ns/1ps
// Behaviour
// [R1] Request type, low address ride strobe zero
// [R2] High address lines ride strobe one
// [R3] Parity high when even count low
// [R4] Upper address: bit zero, then bit one
// [R5] Lower address: bit one, then bit zero
// [R6] Request type: bit one, then bit zero
// [R7] Bus clock times all driving and latching
// [R8] First sub-phase address, second type information
// [R9] Valid strobe starts checking and decode
// [R10] Receiver flags parity mismatch per sub-phase
module apsp_agent
	import apsp_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Bus
	apsp_bus_if.agent       bus,
	// Received phase, clk domain
	output logic            rx_valid,
	output apsp_addr_t      rx_addr,
	output apsp_addr_t      rx_info,
	output apsp_req_t       rx_type_a,
	output apsp_req_t       rx_type_b,
	output logic [1:0]      rx_par_err_sp1,
	output logic [1:0]      rx_par_err_sp2,
	output logic            rx_seq_err,
	output logic            rx_overrun
);

	typedef enum logic {APSP_B_IDLE, APSP_B_SP2} apsp_bst_t;

	// Bus clock domain state
	logic       brst_s1_r;
	logic       brst_s2_r;
	logic       brst_s3_r;
	logic       brst_n_r;
	apsp_bst_t  bst_r;
	apsp_bst_t  bst_nxt;
	apsp_addr_t sp1_addr_r;
	apsp_req_t  sp1_req_r;
	logic [1:0] err1_r;
	apsp_addr_t x_addr_r;
	apsp_addr_t x_info_r;
	apsp_req_t  x_ta_r;
	apsp_req_t  x_tb_r;
	logic [1:0] x_err1_r;
	logic [1:0] x_err2_r;
	logic       x_seq_r;
	logic       x_ovr_r;
	logic       ovr_r;
	logic       seq_r;
	logic       x_tgl_r;
	logic       ack_s1_r;
	logic       ack_s2_r;
	logic       ack_s3_r;
	logic       ack_seen_r;

	// Clk domain state
	logic       tgl_s1_r;
	logic       tgl_s2_r;
	logic       tgl_s3_r;
	logic       tgl_seen_r;
	logic       ack_tgl_r;
	logic       valid_r;
	apsp_addr_t addr_r;
	apsp_addr_t info_r;
	apsp_req_t  ta_r;
	apsp_req_t  tb_r;
	logic [1:0] perr1_r;
	logic [1:0] perr2_r;
	logic       seq_out_r;
	logic       ovr_out_r;

	// Strobe-qualified sampling of the bus
	wire        avs_on    = ~bus.address_valid_strobe_n;
	wire        stb_low   = ~bus.address_source_strobes_n[STB_LOW];
	wire        stb_high  = ~bus.address_source_strobes_n[STB_HIGH];
	wire        sp1_seen  = avs_on & stb_low & stb_high; // R1 R2 R9
	wire        sp2_seen  = ~stb_low & ~stb_high; // R1 R2
	wire [1:0]  exp_sp1   = apsp_parity(bus.addr_n, bus.req_type_n, 1'b0); // R3 R4 R5 R6
	wire [1:0]  exp_sp2   = apsp_parity(bus.addr_n, bus.req_type_n, 1'b1); // R3 R4 R5 R6
	wire [1:0]  mis_sp1   = exp_sp1 ^ bus.address_parity_bits_n; // R10
	wire [1:0]  mis_sp2   = exp_sp2 ^ bus.address_parity_bits_n; // R10
	wire        busy      = x_tgl_r ^ ack_seen_r;
	wire        publish   = (bst_r == APSP_B_SP2) & sp2_seen;
	wire        abort     = (bst_r == APSP_B_SP2) & ~sp2_seen;
	wire        tgl_agree = tgl_s2_r == tgl_s3_r;
	wire        ack_agree = ack_s2_r == ack_s3_r;
	wire        new_word  = tgl_agree & (tgl_s3_r != tgl_seen_r);

	// Reset enters the bus clock domain through three stages
	always_ff @(posedge bus.bclk)
	begin
		brst_s1_r <= rst_n;
		brst_s2_r <= brst_s1_r;
		brst_s3_r <= brst_s2_r;
		if (brst_s2_r == brst_s3_r)
			brst_n_r <= brst_s3_r;
	end

	always_comb
	begin
		bst_nxt = bst_r;
		case (bst_r)
			APSP_B_IDLE: bst_nxt = sp1_seen ? APSP_B_SP2 : APSP_B_IDLE; // R9
			APSP_B_SP2:  bst_nxt = APSP_B_IDLE;
			default:     bst_nxt = APSP_B_IDLE;
		endcase
	end

	// All bus capture is on the rising edge of the bus clock
	always_ff @(posedge bus.bclk)
	begin
		if (!brst_n_r)
			bst_r <= APSP_B_IDLE;
		else
			bst_r <= bst_nxt; // R7
	end

	always_ff @(posedge bus.bclk)
	begin
		if ((bst_r == APSP_B_IDLE) && sp1_seen)
		begin
			sp1_addr_r[LOW_GRP_TOP:ADDR_LO]  <= ~bus.addr_n[LOW_GRP_TOP:ADDR_LO]; // R1 R8
			sp1_req_r                        <= ~bus.req_type_n; // R1
			sp1_addr_r[ADDR_HI:HIGH_GRP_BOT] <= ~bus.addr_n[ADDR_HI:HIGH_GRP_BOT]; // R2 R8
			err1_r                           <= mis_sp1; // R10
		end
	end

	// Word handed to the clk domain; held while the crossing is busy
	always_ff @(posedge bus.bclk)
	begin
		if (!brst_n_r)
		begin
			x_tgl_r <= 1'b0;
			ovr_r   <= 1'b0;
			seq_r   <= 1'b0;
			x_seq_r <= 1'b0;
			x_ovr_r <= 1'b0;
		end
		else if (publish && !busy)
		begin
			x_addr_r <= sp1_addr_r;
			x_info_r <= ~bus.addr_n; // R8
			x_ta_r   <= sp1_req_r;
			x_tb_r   <= ~bus.req_type_n;
			x_err1_r <= err1_r;
			x_err2_r <= mis_sp2; // R10
			x_seq_r  <= seq_r;
			x_ovr_r  <= ovr_r;
			x_tgl_r  <= ~x_tgl_r;
			ovr_r    <= 1'b0;
			seq_r    <= 1'b0;
		end
		else
		begin
			ovr_r <= ovr_r | (publish & busy);
			seq_r <= seq_r | abort;
		end
	end

	always_ff @(posedge bus.bclk)
	begin
		ack_s1_r <= ack_tgl_r;
		ack_s2_r <= ack_s1_r;
		ack_s3_r <= ack_s2_r;
	end

	always_ff @(posedge bus.bclk)
	begin
		if (!brst_n_r)
			ack_seen_r <= 1'b0;
		else if (ack_agree)
			ack_seen_r <= ack_s3_r;
	end

	// Clk domain side of the crossing
	always_ff @(posedge clk)
	begin
		tgl_s1_r <= x_tgl_r;
		tgl_s2_r <= tgl_s1_r;
		tgl_s3_r <= tgl_s2_r;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tgl_seen_r <= 1'b0;
			ack_tgl_r  <= 1'b0;
			valid_r    <= 1'b0;
		end
		else
		begin
			if (tgl_agree)
				tgl_seen_r <= tgl_s3_r;
			// Plain ifs keep the ack toggle known while the bus clock side is still in reset
			if (new_word)
			begin
				ack_tgl_r <= ~ack_tgl_r;
				valid_r   <= 1'b1;
			end
			else
				valid_r   <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			addr_r    <= '0;
			info_r    <= '0;
			ta_r      <= '0;
			tb_r      <= '0;
			perr1_r   <= '0;
			perr2_r   <= '0;
			seq_out_r <= 1'b0;
			ovr_out_r <= 1'b0;
		end
		else if (new_word)
		begin
			addr_r    <= x_addr_r;
			info_r    <= x_info_r;
			ta_r      <= x_ta_r;
			tb_r      <= x_tb_r;
			perr1_r   <= x_err1_r; // R10
			perr2_r   <= x_err2_r; // R10
			seq_out_r <= x_seq_r;
			ovr_out_r <= x_ovr_r;
		end
	end

	assign rx_valid       = valid_r;
	assign rx_addr        = addr_r;
	assign rx_info        = info_r;
	assign rx_type_a      = ta_r;
	assign rx_type_b      = tb_r;
	assign rx_par_err_sp1 = perr1_r;
	assign rx_par_err_sp2 = perr2_r;
	assign rx_seq_err     = seq_out_r;
	assign rx_overrun     = ovr_out_r;

endmodule

// ==== bench/apsp_sva.sv ====
`timescale 1ns/1ps
module apsp_sva
	import apsp_pkg::*;
(
	// Clocks and reset
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       bclk,
	// Bus wires
	input wire apsp_addr_t addr_n,
	input wire logic       addr_oe,
	input wire apsp_req_t  req_type_n,
	input wire logic       req_type_oe,
	input wire logic [1:0] address_parity_bits_n,
	input wire logic       address_valid_strobe_n,
	input wire logic [1:0] address_source_strobes_n,
	input wire logic       address_source_strobes_oe,
	// Injected parity flip
	input wire logic [1:0] req_bad_parity
);
	wire       sp1 = addr_oe && !address_valid_strobe_n && address_source_strobes_n == 2'b00;
	wire       sp2 = addr_oe && address_valid_strobe_n && address_source_strobes_n == 2'b11;
	wire       ph  = ~^(~addr_n[ADDR_HI:PAR_SPLIT]);
	wire       pl  = ~^{~addr_n[PAR_SPLIT-1:ADDR_LO], ~req_type_n};
	wire [1:0] p   = address_parity_bits_n ^ req_bad_parity;

	strobe_pair_a: assert property (@(posedge bclk) disable iff (!rst_n) sp1 |=> sp2)
		else $error("second sub-phase missing");
	phase_release_a: assert property (@(posedge bclk) disable iff (!rst_n)
		sp2 && $past(sp1) |=> !addr_oe && !address_source_strobes_oe)
		else $error("bus not released after phase");
	valid_qual_a: assert property (@(posedge bclk) disable iff (!rst_n)
		!address_valid_strobe_n |-> sp1 ##1 address_valid_strobe_n)
		else $error("valid strobe not one cycle with sub-phase one");
	oe_group_a: assert property (@(posedge clk) disable iff (!rst_n)
		addr_oe == req_type_oe && addr_oe == address_source_strobes_oe)
		else $error("lines and strobes not driven together");
	bclk_div_a: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(bclk) |=> !$changed(bclk) ##1 $changed(bclk))
		else $error("bus clock period wrong");
	launch_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(address_source_strobes_n) |-> $fell(bclk))
		else $error("strobes changed off bus clock fall");
	sp1_hi_par_a: assert property (@(posedge bclk) disable iff (!rst_n) sp1 |-> p[0] == ph)
		else $error("parity bit zero wrong in sub-phase one");
	sp1_lo_par_a: assert property (@(posedge bclk) disable iff (!rst_n) sp1 |-> p[1] == pl)
		else $error("parity bit one wrong in sub-phase one");
	sp2_hi_par_a: assert property (@(posedge bclk) disable iff (!rst_n) sp2 |-> p[1] == ph)
		else $error("parity bit one wrong in sub-phase two");
	sp2_lo_par_a: assert property (@(posedge bclk) disable iff (!rst_n) sp2 |-> p[0] == pl)
		else $error("parity bit zero wrong in sub-phase two");

	cover property (@(posedge bclk) sp1 && req_bad_parity == 2'b11);
	cover property (@(posedge bclk) sp2 ##1 !addr_oe);
	cover property (@(posedge bclk) sp1 && !addr_n[ADDR_HI]);
endmodule

// ==== bench/address_phase_strobe_parity_test.sv ====
`timescale 1ns/1ps
module address_phase_strobe_parity_test;
	import apsp_pkg::*;
	logic       clk = 1'b0;
	logic       rst_n;
	logic       req_valid;
	logic       req_ready;
	apsp_addr_t req_addr;
	apsp_addr_t req_info;
	apsp_req_t  req_type_a;
	apsp_req_t  req_type_b;
	logic [1:0] req_bad_parity;
	logic       phase_done;
	logic       rx_valid;
	apsp_addr_t rx_addr;
	apsp_addr_t rx_info;
	apsp_req_t  rx_type_a;
	apsp_req_t  rx_type_b;
	logic [1:0] rx_par_err_sp1;
	logic [1:0] rx_par_err_sp2;
	logic       rx_seq_err;
	logic       rx_overrun;
	apsp_addr_t w_addr;
	apsp_addr_t w_info;
	apsp_req_t  w_ta;
	logic [1:0] w_p1;
	logic [1:0] w_p2;
	logic [1:0] w_stb;
	int         bad_count = 0;
	int         num_checks = 0;
	int         cycles = 0;
	int         done_cnt = 0;
	int         pos [6] = '{3, 16, 17, 23, 24, 35};

	always #12.5 clk = ~clk;

	apsp_bus_if bus ();
	apsp_requester u_apsp_requester (.clk(clk), .rst_n(rst_n), .bus(bus),
		.req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
		.req_info(req_info), .req_type_a(req_type_a), .req_type_b(req_type_b),
		.req_bad_parity(req_bad_parity), .phase_done(phase_done));
	apsp_agent u_apsp_agent (.clk(clk), .rst_n(rst_n), .bus(bus), .rx_valid(rx_valid),
		.rx_addr(rx_addr), .rx_info(rx_info), .rx_type_a(rx_type_a), .rx_type_b(rx_type_b),
		.rx_par_err_sp1(rx_par_err_sp1), .rx_par_err_sp2(rx_par_err_sp2),
		.rx_seq_err(rx_seq_err), .rx_overrun(rx_overrun));
	apsp_sva u_apsp_sva (.clk(clk), .rst_n(rst_n), .bclk(bus.bclk), .addr_n(bus.addr_n),
		.addr_oe(bus.addr_oe), .req_type_n(bus.req_type_n), .req_type_oe(bus.req_type_oe),
		.address_parity_bits_n(bus.address_parity_bits_n),
		.address_valid_strobe_n(bus.address_valid_strobe_n),
		.address_source_strobes_n(bus.address_source_strobes_n),
		.address_source_strobes_oe(bus.address_source_strobes_oe),
		.req_bad_parity(req_bad_parity));

	// Capture what the wire carried in each sub-phase
	always @(posedge bus.bclk)
	begin
		if (bus.addr_oe && !bus.address_valid_strobe_n)
		begin
			w_addr <= bus.addr_n;
			w_ta   <= bus.req_type_n;
			w_p1   <= bus.address_parity_bits_n;
			w_stb  <= bus.address_source_strobes_n;
		end
		if (bus.addr_oe && bus.address_valid_strobe_n)
		begin
			w_info <= bus.addr_n;
			w_p2   <= bus.address_parity_bits_n;
		end
	end

	// Pin parity from active-high values: high when an even count of ones
	function automatic logic [1:0] exp_par(input apsp_addr_t a, input apsp_req_t r,
		input logic sp2);
		logic hi;
		logic lo;
		hi = ~^a[ADDR_HI:PAR_SPLIT];
		lo = ~^{a[PAR_SPLIT-1:ADDR_LO], r};
		return sp2 ? {hi, lo} : {lo, hi};
	endfunction

	task automatic end_of_test();
		if (bad_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk_addr(input apsp_addr_t got, input apsp_addr_t exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_req(input apsp_req_t got, input apsp_req_t exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic run(input apsp_addr_t a, input apsp_addr_t i, input apsp_req_t ta,
		input apsp_req_t tb, input logic [1:0] bad);
		int n;
		int d0;
		n = 0;
		while (req_ready !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 400)
			bad_count++;
		d0             = done_cnt;
		req_valid      = 1'b1;
		req_addr       = a;
		req_info       = i;
		req_type_a     = ta;
		req_type_b     = tb;
		req_bad_parity = bad;
		@(negedge clk);
		req_valid = 1'b0;
		n = 0;
		while (rx_valid !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 400)
			bad_count++;
		chk2(2'(done_cnt - d0), 2'h1);
		chk2({1'b0, req_ready}, 2'h1);
		chk_addr(rx_addr, a);
		chk_addr(rx_info, i);
		chk_req(rx_type_a, ta);
		chk_req(rx_type_b, tb);
		chk2(rx_par_err_sp1, bad);
		chk2(rx_par_err_sp2, bad);
		chk2({rx_seq_err, rx_overrun}, 2'b00);
		chk_addr(w_addr, ~a);
		chk_req(w_ta, ~ta);
		chk_addr(w_info, ~i);
		chk2(w_p1, exp_par(a, ta, 1'b0) ^ bad);
		chk2(w_p2, exp_par(i, tb, 1'b1) ^ bad);
		chk2(w_stb, 2'b00);
		repeat (24) @(negedge clk);
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (phase_done === 1'b1)
			done_cnt <= done_cnt + 1;
		if (cycles == 4000)
		begin
			bad_count++;
			end_of_test();
		end
	end

	initial
	begin
		rst_n          = 1'b0;
		req_valid      = 1'b0;
		req_addr       = '0;
		req_info       = '0;
		req_type_a     = '0;
		req_type_b     = '0;
		req_bad_parity = 2'b00;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (24) @(negedge clk);
		run('0, '0, '0, '0, 2'b00);
		run('1, '1, '1, '1, 2'b00);
		for (int k = 0; k < 6; k++)
			run(apsp_addr_t'(1) << (pos[k] - 3), ~(apsp_addr_t'(1) << (pos[k] - 3)),
				apsp_req_t'(k + 1), ~apsp_req_t'(k + 1), 2'b00);
		for (int b = 1; b < 4; b++)
			run(33'h1_89AB_CDEF, 33'h0_7654_3210, 5'h15, 5'h0A, 2'(b));
		end_of_test();
	end
endmodule
